// ===== verilog/ctrap_cfg.svh
// constants for the context and bus error trap unit
// assumes inclusion by bare name from package and design
`ifndef CTRAP_CFG_SVH
`define CTRAP_CFG_SVH
`define CTRAP_CLASS_CTX 3'h3
`define CTRAP_CLASS_BUS 3'h4
`define CTRAP_TIN_DEPLETION 8'h01
`define CTRAP_TIN_DEPTH_OVF 8'h02
`define CTRAP_TIN_DEPTH_UNF 8'h03
`define CTRAP_TIN_FREE_UNF 8'h04
`define CTRAP_TIN_STACK_EMPTY 8'h05
`define CTRAP_TIN_KIND 8'h06
`define CTRAP_TIN_NESTING_ERROR_TRAP 8'h07
`define CTRAP_TIN_FETCH_SE 8'h01
`define CTRAP_TIN_LOAD_SE 8'h02
`define CTRAP_TIN_STORE_AE 8'h03
`define CTRAP_TIN_COPROC_AE 8'h04
`define CTRAP_TIN_FETCH_IE 8'h05
`define CTRAP_TIN_DATA_IE 8'h06
`define CTRAP_VEC_SHIFT 5
`define CTRAP_SCRATCH_BASE 32'hD0000000
`define CTRAP_SCRATCH_LAST 32'hD3FFFFFF
`define CTRAP_SCRATCH_SIZE 32'h00010000
`define CTRAP_DEPTH_MAX 7'h3F
`endif

// ===== verilog/ctrap_pkg.sv
// types for the context and bus error trap unit
// assumes ctrap_cfg.svh on the include path
`include "ctrap_cfg.svh"
package ctrap_pkg;
	typedef enum logic [1:0] {
		CTRAP_IDLE = 2'b00,
		CTRAP_DEPL = 2'b01,
		CTRAP_FATAL = 2'b10
	} ctrap_state_t;
endpackage

// ===== verilog/ctrap_unit.sv
// trap detection and classification for context and bus errors
// assumes single core clock; inputs come from same-clock pipeline logic
`timescale 1ns/1ps
`default_nettype none
`include "ctrap_cfg.svh"

// Functional notes
// RULE1: context save/restore conditions report trap class 3.
// RULE2: save using limit-pointer area completes, then depletion trap id 1.
// RULE3: depletion after trap/interrupt entry returns to handler's first instruction.
// RULE4: taking depletion trap consumes one more save area.
// RULE5: software keeps two spare save areas beyond limit pointer.
// RULE6: every depletion trap sets depletion-in-progress flag.
// RULE7: call at maximum depth with counting on raises id 2.
// RULE8: return at depth zero with counting on raises id 3.
// RULE9: save with null free-list head raises id 4.
// RULE10: any save/restore error abandons, jumps to underflow handler, id 4.
// RULE11: restore with null previous pointer raises id 5.
// RULE12: restore kind mismatching saved upper/lower flag raises id 6.
// RULE13: exception return at nonzero depth with counting on raises id 7.
// RULE14: fetch bus error or non-code segment raises class 4 id 1.
// RULE15: fetch in scratchpad window beyond implemented memory is fetch error.
// RULE16: load bus error, scratchpad overrun, refill load error raise id 2.
// RULE17: store, cache op, writeback errors raise asynchronous id 3.
// RULE18: any coprocessor error raises shared asynchronous id 4.
// RULE19: integrity error anywhere in fetch group raises id 5.
// RULE20: data integrity error raises id 6.
// RULE21: trap entry writes id into data register 15.
// RULE22: entry address is class shifted left five ORed with vector base.
// RULE23: free-list underflow outranks every other exception.
module ctrap_unit import ctrap_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// context engine
	input wire logic save_req_i,
	input wire logic save_from_entry_i,
	input wire logic restore_req_i,
	input wire logic restore_upper_i,
	input wire logic ctx_op_error_i,
	input wire logic [31:0] free_list_head_pointer_i,
	input wire logic [31:0] context_limit_pointer_i,
	input wire logic [31:0] previous_context_pointer_i,
	input wire logic saved_upper_lower_flag_i,
	// instructions
	input wire logic call_i,
	input wire logic ret_i,
	input wire logic exception_return_instr_i,
	input wire logic depth_count_en_i,
	input wire logic [6:0] call_depth_count_i,
	// fetch path
	input wire logic fetch_i,
	input wire logic [31:0] fetch_addr_i,
	input wire logic fetch_bus_err_i,
	input wire logic fetch_no_code_i,
	input wire logic fetch_integrity_err_i,
	// data path
	input wire logic load_bus_err_i,
	input wire logic data_access_i,
	input wire logic [31:0] data_addr_i,
	input wire logic refill_load_err_i,
	input wire logic store_bus_err_i,
	input wire logic cache_op_err_i,
	input wire logic writeback_err_i,
	input wire logic data_integrity_err_i,
	input wire logic [3:0] coproc_err_i,
	// vector base and software flag clear
	input wire logic [31:0] vector_base_register_i,
	input wire logic depl_flag_clr_i,
	// trap outputs
	output logic trap_o,
	output logic [2:0] trap_class_o,
	output logic [7:0] trap_ident_number_o,
	output logic [31:0] trap_vector_o,
	output logic data_register_15_we_o,
	output logic [31:0] data_register_15_o,
	output logic ret_to_handler_first_o,
	output logic extra_save_o,
	output logic abandon_ctx_o,
	output logic depletion_in_progress_flag_o
);
	logic rst_s1_ff;
	logic rst_s2_ff;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	wire logic rst_n = rst_s2_ff;

	function automatic logic in_scratch_gap(input logic [31:0] a);
		in_scratch_gap = (a >= `CTRAP_SCRATCH_BASE) && (a <= `CTRAP_SCRATCH_LAST) &&
			(a >= (`CTRAP_SCRATCH_BASE + `CTRAP_SCRATCH_SIZE));
	endfunction

	ctrap_state_t state_ff, nxt_state;
	logic trap_ff, nxt_trap;
	logic [2:0] cls_ff, nxt_cls;
	logic [7:0] tin_ff, nxt_tin;
	logic [31:0] vec_ff, nxt_vec;
	logic rfirst_ff, nxt_rfirst;
	logic extra_ff, nxt_extra;
	logic aban_ff, nxt_aban;
	logic flag_ff, nxt_flag;
	logic depl_src_ff, nxt_depl_src;

	logic free_unf;
	logic depleting;
	logic sync_hit;
	logic [2:0] c;
	logic [7:0] t;

	// helper terms for the checks below
	logic async_cause;
	logic fetch_err_hit;
	logic fetch_cause;
	logic above_ctx;
	logic stack_hit;
	logic ovf_hit;
	logic unf_hit;
	logic nesting_error_trap_hit;
	logic kind_hit;
	logic load_hit;
	always_comb begin
		async_cause = store_bus_err_i || cache_op_err_i || writeback_err_i ||
			(|coproc_err_i) || data_integrity_err_i;
		fetch_err_hit = fetch_i && (fetch_bus_err_i || fetch_no_code_i || in_scratch_gap(fetch_addr_i));
		fetch_cause = fetch_err_hit || (fetch_i && fetch_integrity_err_i);
		above_ctx = free_unf || async_cause || fetch_cause || state_ff == CTRAP_DEPL;
		stack_hit = restore_req_i && previous_context_pointer_i == 32'h00000000;
		ovf_hit = call_i && depth_count_en_i && call_depth_count_i == `CTRAP_DEPTH_MAX;
		unf_hit = ret_i && depth_count_en_i && call_depth_count_i == 7'h00;
		nesting_error_trap_hit = exception_return_instr_i && depth_count_en_i && call_depth_count_i != 7'h00;
		kind_hit = restore_req_i && (restore_upper_i != saved_upper_lower_flag_i);
		load_hit = data_access_i && (load_bus_err_i || refill_load_err_i || in_scratch_gap(data_addr_i));
	end
	always_comb begin
		free_unf = (save_req_i && free_list_head_pointer_i == 32'h00000000) ||
			((save_req_i || restore_req_i) && ctx_op_error_i); // see RULE9 see RULE10
		depleting = save_req_i && !free_unf && free_list_head_pointer_i == context_limit_pointer_i; // see RULE2
		nxt_state = state_ff;
		nxt_depl_src = depl_src_ff;
		nxt_rfirst = 1'b0;
		nxt_extra = 1'b0;
		nxt_aban = 1'b0;
		sync_hit = 1'b1;
		c = `CTRAP_CLASS_CTX; // see RULE1
		t = 8'h00;
		if (free_unf) begin
			t = `CTRAP_TIN_FREE_UNF; // see RULE23
			nxt_aban = 1'b1; // see RULE10
		end else if (store_bus_err_i || cache_op_err_i || writeback_err_i) begin
			c = `CTRAP_CLASS_BUS;
			t = `CTRAP_TIN_STORE_AE; // see RULE17
		end else if (|coproc_err_i) begin
			c = `CTRAP_CLASS_BUS;
			t = `CTRAP_TIN_COPROC_AE; // see RULE18
		end else if (data_integrity_err_i) begin
			c = `CTRAP_CLASS_BUS;
			t = `CTRAP_TIN_DATA_IE; // see RULE20
		end else if (fetch_i && (fetch_bus_err_i || fetch_no_code_i || in_scratch_gap(fetch_addr_i))) begin
			c = `CTRAP_CLASS_BUS;
			t = `CTRAP_TIN_FETCH_SE; // see RULE14 see RULE15
		end else if (fetch_i && fetch_integrity_err_i) begin
			c = `CTRAP_CLASS_BUS;
			t = `CTRAP_TIN_FETCH_IE; // see RULE19
		end else if (state_ff == CTRAP_DEPL) begin
			t = `CTRAP_TIN_DEPLETION; // see RULE2
			nxt_rfirst = depl_src_ff; // see RULE3
			nxt_extra = 1'b1; // see RULE4
		end else if (restore_req_i && previous_context_pointer_i == 32'h00000000) begin
			t = `CTRAP_TIN_STACK_EMPTY; // see RULE11
		end else if (call_i && depth_count_en_i && call_depth_count_i == `CTRAP_DEPTH_MAX) begin
			t = `CTRAP_TIN_DEPTH_OVF; // see RULE7
		end else if (ret_i && depth_count_en_i && call_depth_count_i == 7'h00) begin
			t = `CTRAP_TIN_DEPTH_UNF; // see RULE8
		end else if (exception_return_instr_i && depth_count_en_i && call_depth_count_i != 7'h00) begin
			t = `CTRAP_TIN_NESTING_ERROR_TRAP; // see RULE13
		end else if (restore_req_i && (restore_upper_i != saved_upper_lower_flag_i)) begin
			t = `CTRAP_TIN_KIND; // see RULE12
		end else if (data_access_i && (load_bus_err_i || refill_load_err_i || in_scratch_gap(data_addr_i))) begin
			c = `CTRAP_CLASS_BUS;
			t = `CTRAP_TIN_LOAD_SE; // see RULE16
		end else begin
			sync_hit = 1'b0;
		end
		case (state_ff)
			CTRAP_IDLE: begin
				if (free_unf) begin
					nxt_state = CTRAP_FATAL;
				end else if (depleting) begin
					nxt_state = CTRAP_DEPL; // see RULE2
					nxt_depl_src = save_from_entry_i;
				end
			end
			CTRAP_DEPL: begin
				if (free_unf) begin
					nxt_state = CTRAP_FATAL;
				end else if (t == `CTRAP_TIN_DEPLETION && c == `CTRAP_CLASS_CTX) begin
					nxt_state = CTRAP_IDLE;
				end
			end
			CTRAP_FATAL: nxt_state = CTRAP_FATAL;
			default: nxt_state = CTRAP_IDLE;
		endcase
		nxt_trap = sync_hit;
		nxt_cls = sync_hit ? c : cls_ff;
		nxt_tin = sync_hit ? t : tin_ff;
		nxt_vec = sync_hit ? (vector_base_register_i | (32'(c) << `CTRAP_VEC_SHIFT)) : vec_ff; // see RULE22
		nxt_flag = flag_ff;
		if (depl_flag_clr_i) begin
			nxt_flag = 1'b0;
		end
		if (sync_hit && c == `CTRAP_CLASS_CTX && t == `CTRAP_TIN_DEPLETION) begin
			nxt_flag = 1'b1; // see RULE6
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= CTRAP_IDLE;
			trap_ff <= 1'b0;
			cls_ff <= 3'h0;
			tin_ff <= 8'h00;
			vec_ff <= 32'h00000000;
			rfirst_ff <= 1'b0;
			extra_ff <= 1'b0;
			aban_ff <= 1'b0;
			flag_ff <= 1'b0;
			depl_src_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			trap_ff <= nxt_trap;
			cls_ff <= nxt_cls;
			tin_ff <= nxt_tin;
			vec_ff <= nxt_vec;
			rfirst_ff <= nxt_rfirst;
			extra_ff <= nxt_extra;
			aban_ff <= nxt_aban;
			flag_ff <= nxt_flag;
			depl_src_ff <= nxt_depl_src;
		end
	end

	assign trap_o = trap_ff;
	assign trap_class_o = cls_ff;
	assign trap_ident_number_o = tin_ff;
	assign trap_vector_o = vec_ff;
	assign data_register_15_we_o = trap_ff; // see RULE21
	assign data_register_15_o = {24'h000000, tin_ff};
	assign ret_to_handler_first_o = rfirst_ff;
	assign extra_save_o = extra_ff;
	assign abandon_ctx_o = aban_ff;
	assign depletion_in_progress_flag_o = flag_ff;

	// context trap checks, with vector, register 15 and asynchronous bus error checks
	a_free_unf_first: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE23
		free_unf |=> trap_o && trap_class_o == 3'h3 && trap_ident_number_o == 8'h04 && abandon_ctx_o)
		else $error("free list underflow not reported");
	a_depl_follows: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE2
		(state_ff == CTRAP_IDLE && depleting && !free_unf)
		|=> !(trap_o && trap_ident_number_o == 8'h01 && trap_class_o == 3'h3)
		##[1:40] (trap_o && trap_ident_number_o == 8'h01))
		else $error("depletion trap not taken after save");
	a_depl_flag_set: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE6
		(trap_o && trap_class_o == 3'h3 && trap_ident_number_o == 8'h01) |-> depletion_in_progress_flag_o)
		else $error("depletion flag not set");
	a_depl_extra: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE4
		extra_save_o |-> trap_o && trap_ident_number_o == 8'h01)
		else $error("extra save without depletion trap");
	a_vector_form: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE22
		$rose(trap_o) |-> trap_vector_o == ($past(vector_base_register_i) | (32'(trap_class_o) << 5)))
		else $error("vector address wrong");
	a_d15_tin: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE21
		data_register_15_we_o |-> data_register_15_o[7:0] == trap_ident_number_o && trap_o)
		else $error("data register 15 mismatch");
	a_depth_ovf: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE7
		(call_i && depth_count_en_i && call_depth_count_i == 7'h3F && !free_unf && !fetch_i && !store_bus_err_i
		&& !cache_op_err_i && !writeback_err_i && coproc_err_i == 4'h0 && !data_integrity_err_i
		&& state_ff != CTRAP_DEPL && !restore_req_i) |=> trap_ident_number_o == 8'h02 && trap_class_o == 3'h3)
		else $error("depth overflow missed");
	a_store_async: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE17
		(store_bus_err_i && !free_unf) |=> trap_class_o == 3'h4 && trap_ident_number_o == 8'h03)
		else $error("store error missed");
	a_coproc: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE18
		(|coproc_err_i && !free_unf && !store_bus_err_i && !cache_op_err_i && !writeback_err_i)
		|=> trap_class_o == 3'h4 && trap_ident_number_o == 8'h04)
		else $error("coprocessor error missed");
	// further context trap checks
	a_free_list_null: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE9
		(save_req_i && free_list_head_pointer_i == 32'h00000000)
		|=> trap_o && trap_ident_number_o == `CTRAP_TIN_FREE_UNF && abandon_ctx_o)
		else $error("empty free list save not trapped");

	a_ctx_err_abandon: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE10
		((save_req_i || restore_req_i) && ctx_op_error_i)
		|=> abandon_ctx_o && data_register_15_we_o && data_register_15_o == {24'h000000, `CTRAP_TIN_FREE_UNF})
		else $error("context error not abandoned");

	a_stack_empty: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE11
		(stack_hit && !above_ctx)
		|=> trap_o && trap_class_o == `CTRAP_CLASS_CTX && trap_ident_number_o == `CTRAP_TIN_STACK_EMPTY)
		else $error("empty call stack not trapped");

	a_depth_unf: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE8
		(unf_hit && !above_ctx && !stack_hit && !ovf_hit)
		|=> trap_o && trap_class_o == `CTRAP_CLASS_CTX && trap_ident_number_o == `CTRAP_TIN_DEPTH_UNF)
		else $error("depth underflow missed");

	a_nesting_error_trap_error: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE13
		(nesting_error_trap_hit && !above_ctx && !stack_hit && !ovf_hit && !unf_hit)
		|=> trap_o && trap_class_o == `CTRAP_CLASS_CTX && trap_ident_number_o == `CTRAP_TIN_NESTING_ERROR_TRAP)
		else $error("nesting error missed");

	a_kind_error: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE12
		(kind_hit && !above_ctx && !stack_hit && !ovf_hit && !unf_hit && !nesting_error_trap_hit)
		|=> trap_o && trap_class_o == `CTRAP_CLASS_CTX && trap_ident_number_o == `CTRAP_TIN_KIND)
		else $error("context kind error missed");

	a_depl_return: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE3
		ret_to_handler_first_o
		|-> trap_o && trap_class_o == `CTRAP_CLASS_CTX && trap_ident_number_o == `CTRAP_TIN_DEPLETION)
		else $error("handler return without depletion trap");

	a_flag_hold: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE6
		(depletion_in_progress_flag_o && !depl_flag_clr_i)
		|=> depletion_in_progress_flag_o)
		else $error("depletion flag lost without clear");

	// bus trap checks, then vector and no-cause checks
	a_fetch_sync: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE14
		(fetch_err_hit && !free_unf && !async_cause)
		|=> trap_o && trap_class_o == `CTRAP_CLASS_BUS && trap_ident_number_o == `CTRAP_TIN_FETCH_SE)
		else $error("fetch error missed");

	a_fetch_gap: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE15
		(fetch_i && in_scratch_gap(fetch_addr_i) && !free_unf && !async_cause)
		|=> trap_o && trap_class_o == `CTRAP_CLASS_BUS && trap_ident_number_o == `CTRAP_TIN_FETCH_SE)
		else $error("scratchpad gap fetch missed");

	a_fetch_integrity: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE19
		(fetch_i && fetch_integrity_err_i && !fetch_err_hit && !free_unf && !async_cause)
		|=> trap_o && trap_class_o == `CTRAP_CLASS_BUS && trap_ident_number_o == `CTRAP_TIN_FETCH_IE)
		else $error("fetch integrity error missed");

	a_data_integrity: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE20
		(data_integrity_err_i && !free_unf && !store_bus_err_i && !cache_op_err_i && !writeback_err_i && coproc_err_i == 4'h0)
		|=> trap_o && trap_class_o == `CTRAP_CLASS_BUS && trap_ident_number_o == `CTRAP_TIN_DATA_IE)
		else $error("data integrity error missed");

	a_load_sync: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE16
		(load_hit && !above_ctx && !stack_hit && !ovf_hit && !unf_hit && !nesting_error_trap_hit && !kind_hit)
		|=> trap_o && trap_class_o == `CTRAP_CLASS_BUS && trap_ident_number_o == `CTRAP_TIN_LOAD_SE)
		else $error("load error missed");

	a_vec_every: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE22
		trap_o
		|-> trap_vector_o == ($past(vector_base_register_i) | (32'(trap_class_o) << `CTRAP_VEC_SHIFT)))
		else $error("vector address wrong on trap");

	a_quiet_no_trap: assert property (@(posedge mclk_i) disable iff (!rst_n) // see RULE1
		(!above_ctx && !stack_hit && !ovf_hit && !unf_hit && !nesting_error_trap_hit && !kind_hit && !load_hit)
		|=> !trap_o)
		else $error("trap without cause");

	// cover points
	c_depletion: cover property (@(posedge mclk_i) disable iff (!rst_n)
		trap_o && trap_ident_number_o == 8'h01 && ret_to_handler_first_o);
	c_fatal: cover property (@(posedge mclk_i) disable iff (!rst_n)
		abandon_ctx_o);
	c_fetch_err: cover property (@(posedge mclk_i) disable iff (!rst_n)
		trap_o && trap_class_o == 3'h4 && trap_ident_number_o == 8'h01);
	c_nesting_error_trap_error: cover property (@(posedge mclk_i) disable iff (!rst_n)
		trap_o && trap_class_o == 3'h3 && trap_ident_number_o == 8'h07);
	c_data_integrity: cover property (@(posedge mclk_i) disable iff (!rst_n)
		trap_o && trap_class_o == 3'h4 && trap_ident_number_o == 8'h06);
endmodule // ctrap_unit
`default_nettype wire

// ===== tb/ctrap_ctx_model.sv
// free context list model: head, limit and previous-context pointers
// assumes the unit's clock and raw reset; one save area is 64 bytes
`timescale 1ns/1ps
`default_nettype none
module ctrap_ctx_model #(
	parameter logic [31:0] LIMIT = 32'h0000_1000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// save activity
	input wire logic save_i,
	input wire logic extra_save_i,
	// pointers
	output logic [31:0] head_o,
	output logic [31:0] limit_o,
	output logic [31:0] prev_o
);
	logic [31:0] head_ff;
	logic [31:0] prev_ff;
	// two spare areas past the limit, then the list runs empty
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			head_ff <= LIMIT - 32'h40;
			prev_ff <= 32'h0;
		end else if (save_i || extra_save_i) begin
			prev_ff <= head_ff;
			head_ff <= (head_ff == LIMIT + 32'h80 || head_ff == 32'h0) ? 32'h0 : head_ff + 32'h40;
		end
	end
	assign head_o = head_ff;
	assign limit_o = LIMIT;
	assign prev_o = prev_ff;
endmodule // ctrap_ctx_model
`default_nettype wire

// ===== tb/ctrap_unit_tb.sv
// self-checking bench for the trap unit
// assumes ctrap_cfg.svh on the include path and the list model beside it
`timescale 1ns/1ps
`default_nettype none
`include "ctrap_cfg.svh"
module ctrap_unit_tb;
	localparam logic [31:0] SAFE = 32'h8000_0000;
	localparam logic [7:0] BID [13] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h03, 8'h03, 8'h03,
		8'h04, 8'h04, 8'h04, 8'h04, 8'h05, 8'h06};
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic save_req_i = 1'b0, save_from_entry_i = 1'b0, restore_req_i = 1'b0, restore_upper_i = 1'b0;
	logic ctx_op_error_i = 1'b0, saved_upper_lower_flag_i = 1'b0, depl_flag_clr_i = 1'b0;
	logic call_i = 1'b0, ret_i = 1'b0, exception_return_instr_i = 1'b0, depth_count_en_i = 1'b0;
	logic fetch_i = 1'b0, data_access_i = 1'b0;
	logic [6:0] call_depth_count_i = 7'h0;
	logic [31:0] fetch_addr_i = SAFE, data_addr_i = SAFE, vector_base_register_i = 32'h100;
	logic [12:0] berr = 13'h0;
	logic [31:0] head, limit, prev;
	logic trap_o, data_register_15_we_o, ret_to_handler_first_o, extra_save_o, abandon_ctx_o;
	logic depletion_in_progress_flag_o;
	logic [2:0] trap_class_o;
	logic [7:0] trap_ident_number_o;
	logic [31:0] trap_vector_o, data_register_15_o;
	int fail_count = 0, checked = 0, cycles = 0;

	ctrap_unit dut (.mclk_i, .rst_b_i, .save_req_i, .save_from_entry_i, .restore_req_i, .restore_upper_i,
		.ctx_op_error_i, .free_list_head_pointer_i(head), .context_limit_pointer_i(limit),
		.previous_context_pointer_i(prev), .saved_upper_lower_flag_i, .call_i, .ret_i, .exception_return_instr_i,
		.depth_count_en_i, .call_depth_count_i, .fetch_i, .fetch_addr_i, .fetch_bus_err_i(berr[0]),
		.fetch_no_code_i(berr[1]), .fetch_integrity_err_i(berr[11]), .load_bus_err_i(berr[2]), .data_access_i,
		.data_addr_i, .refill_load_err_i(berr[3]), .store_bus_err_i(berr[4]), .cache_op_err_i(berr[5]),
		.writeback_err_i(berr[6]), .data_integrity_err_i(berr[12]), .coproc_err_i(berr[10:7]),
		.vector_base_register_i, .depl_flag_clr_i, .trap_o, .trap_class_o, .trap_ident_number_o, .trap_vector_o,
		.data_register_15_we_o, .data_register_15_o, .ret_to_handler_first_o, .extra_save_o, .abandon_ctx_o,
		.depletion_in_progress_flag_o);
	ctrap_ctx_model cm (.clk_i(mclk_i), .rst_b_i, .save_i(save_req_i), .extra_save_i(extra_save_o),
		.head_o(head), .limit_o(limit), .prev_o(prev));

	always #12.5 mclk_i = ~mclk_i;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic chk_trap(input logic [2:0] cls, input logic [7:0] id);
		chk1(trap_o, 1'b1);
		chk({29'h0, trap_class_o}, {29'h0, cls});
		chk({24'h0, trap_ident_number_o}, {24'h0, id});
		chk(trap_vector_o, vector_base_register_i | {24'h0, cls, 5'h0});
		chk(data_register_15_o, {24'h0, id});
		chk1(data_register_15_we_o, 1'b1);
	endtask
	// bits: save, entry, restore, upper, saved flag, op error
	task automatic ctx(input logic [5:0] v, input logic [12:0] e);
		@(posedge mclk_i);
		{save_req_i, save_from_entry_i, restore_req_i, restore_upper_i, saved_upper_lower_flag_i, ctx_op_error_i} <= v;
		berr <= e;
		@(posedge mclk_i);
		{save_req_i, save_from_entry_i, restore_req_i, restore_upper_i, ctx_op_error_i} <= 5'h0;
		berr <= 13'h0;
		#1;
	endtask
	// bits: exception return, return, call
	task automatic instr(input logic [2:0] k, input logic en, input logic [6:0] cnt);
		@(posedge mclk_i);
		{exception_return_instr_i, ret_i, call_i} <= k;
		depth_count_en_i <= en;
		call_depth_count_i <= cnt;
		@(posedge mclk_i);
		{exception_return_instr_i, ret_i, call_i} <= 3'h0;
		#1;
	endtask
	task automatic mem(input logic [12:0] e, input logic [31:0] fa, input logic [31:0] da);
		@(posedge mclk_i);
		berr <= e;
		fetch_addr_i <= fa;
		data_addr_i <= da;
		@(posedge mclk_i);
		berr <= 13'h0;
		fetch_addr_i <= SAFE;
		data_addr_i <= SAFE;
		#1;
	endtask

	task automatic ctx_traps;
		ctx(6'b001000, 13'h0);
		chk_trap(`CTRAP_CLASS_CTX, `CTRAP_TIN_STACK_EMPTY);
		ctx(6'b100000, 13'h0);
		chk1(trap_o, 1'b0);
		ctx(6'b001010, 13'h0);
		chk_trap(`CTRAP_CLASS_CTX, `CTRAP_TIN_KIND);
		ctx(6'b001100, 13'h0);
		chk_trap(`CTRAP_CLASS_CTX, `CTRAP_TIN_KIND);
		ctx(6'b001110, 13'h0);
		chk1(trap_o, 1'b0);
	endtask
	task automatic depletion;
		ctx(6'b110000, 13'h0);
		chk1(trap_o, 1'b0);
		@(posedge mclk_i);
		#1;
		chk_trap(`CTRAP_CLASS_CTX, `CTRAP_TIN_DEPLETION);
		chk1(extra_save_o, 1'b1);
		chk1(ret_to_handler_first_o, 1'b1);
		chk1(depletion_in_progress_flag_o, 1'b1);
		@(posedge mclk_i);
		depl_flag_clr_i <= 1'b1;
		@(posedge mclk_i);
		depl_flag_clr_i <= 1'b0;
		#1;
		chk1(depletion_in_progress_flag_o, 1'b0);
	endtask
	task automatic depth_traps;
		instr(3'h1, 1'b1, `CTRAP_DEPTH_MAX - 7'h1);
		chk1(trap_o, 1'b0);
		instr(3'h1, 1'b1, `CTRAP_DEPTH_MAX);
		chk_trap(`CTRAP_CLASS_CTX, `CTRAP_TIN_DEPTH_OVF);
		instr(3'h1, 1'b0, `CTRAP_DEPTH_MAX);
		chk1(trap_o, 1'b0);
		instr(3'h2, 1'b1, 7'h0);
		chk_trap(`CTRAP_CLASS_CTX, `CTRAP_TIN_DEPTH_UNF);
		instr(3'h2, 1'b1, 7'h1);
		chk1(trap_o, 1'b0);
		instr(3'h4, 1'b1, 7'h1);
		chk_trap(`CTRAP_CLASS_CTX, `CTRAP_TIN_NESTING_ERROR_TRAP);
		instr(3'h4, 1'b1, 7'h0);
		chk1(trap_o, 1'b0);
	endtask
	task automatic bus_traps;
		@(posedge mclk_i);
		fetch_i <= 1'b1;
		data_access_i <= 1'b1;
		vector_base_register_i <= 32'h200;
		for (int i = 0; i < 13; i++) begin
			mem(13'h1 << i, SAFE, SAFE);
			chk_trap(`CTRAP_CLASS_BUS, BID[i]);
		end
		mem(13'h0, `CTRAP_SCRATCH_BASE + `CTRAP_SCRATCH_SIZE - 32'h4, SAFE);
		chk1(trap_o, 1'b0);
		mem(13'h0, `CTRAP_SCRATCH_BASE + `CTRAP_SCRATCH_SIZE, SAFE);
		chk_trap(`CTRAP_CLASS_BUS, `CTRAP_TIN_FETCH_SE);
		mem(13'h0, SAFE, `CTRAP_SCRATCH_BASE + `CTRAP_SCRATCH_SIZE);
		chk_trap(`CTRAP_CLASS_BUS, `CTRAP_TIN_LOAD_SE);
	endtask
	task automatic underflow;
		ctx(6'b100000, 13'h0);
		chk1(trap_o, 1'b0);
		ctx(6'b100000, 13'h10);
		chk_trap(`CTRAP_CLASS_CTX, `CTRAP_TIN_FREE_UNF);
		chk1(abandon_ctx_o, 1'b1);
		ctx(6'b001111, 13'h0);
		chk_trap(`CTRAP_CLASS_CTX, `CTRAP_TIN_FREE_UNF);
		chk1(abandon_ctx_o, 1'b1);
	endtask
	task automatic wrap_up;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			wrap_up;
		end
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		ctx_traps;
		depletion;
		depth_traps;
		bus_traps;
		underflow;
		wrap_up;
	end
endmodule // ctrap_unit_tb
`default_nettype wire
